// ---- hw/c22r_cfg.svh ----
`ifndef C22R_CFG_SVH
`define C22R_CFG_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define C22R_OFS_CTRL     5'h00
`define C22R_OFS_STAT     5'h01
`define C22R_OFS_IDH      5'h02
`define C22R_OFS_IDL      5'h03
`define C22R_OFS_MMDC     5'h0D
`define C22R_OFS_MMDD     5'h0E

// ************************************************************
// Reset values
// ************************************************************
`define C22R_RST_CTRL     16'h1100
`define C22R_RST_STAT     16'h1009
`define C22R_RST_MMDC     16'h0000
`define C22R_RST_MMDD     16'h0000

// ************************************************************
// Control word field positions
// ************************************************************
`define C22R_B_SFT_RST    15
`define C22R_B_LOOP       14
`define C22R_B_SPD_LO     13
`define C22R_B_AUTONEG_ENABLE_MIRROR      12
`define C22R_B_PD         11
`define C22R_B_ISO        10
`define C22R_B_RSVD9      9
`define C22R_B_DUPLEX     8
`define C22R_B_COLTEST    7
`define C22R_B_SPD_HI     6
`define C22R_B_UNIDIR     5

// ************************************************************
// Status word field positions
// ************************************************************
`define C22R_B_AN_DONE    5
`define C22R_B_LINK       2

// ************************************************************
// Management frame and timing
// ************************************************************
`define C22R_PRE_ONES     6'h20
`define C22R_HDR_BITS     4'hD
`define C22R_OP_RD        2'h2
`define C22R_OP_WR        2'h1
`define C22R_CLK_MHZ      40
`define C22R_SRST_NS      1000
`define C22R_SRST_CYC     ((`C22R_SRST_NS*`C22R_CLK_MHZ+999)/1000)

`endif

// ---- hw/c22r_pkg.sv ----
package c22r_pkg;

  typedef enum logic [2:0] {
    C22R_PRE   = 3'b000,
    C22R_HDR   = 3'b001,
    C22R_RTA   = 3'b010,
    C22R_RDAT  = 3'b011,
    C22R_WTA   = 3'b100,
    C22R_WDAT  = 3'b101
  } c22r_state_e;

  typedef logic [15:0] c22r_word_t;

endpackage : c22r_pkg

// ---- hw/c22r_regs.sv ----
`timescale 1ns/1ps
`include "c22r_cfg.svh"
// Summary of operation
// - Control word sits at offset 0x0 and resets to 0x1100, or to 0x1900 with the strap pin high.
// - Writing one to bit 15 runs a soft reset; bit self-clears, shared.
// - Bit 14 enables PCS loopback; read/write, shared with vendor alias.
// - Bit 12 reports autoneg enable, read-only here, resets to one.
// - Bit 11 enters soft power-down; management access keeps working.
// - Power-down reset value comes from strap pin; shared with vendor bit.
// - Bit 10 isolates the PHY from the MAC interface; resets to zero.
// - Bit 8 ignores writes, always reads one: full duplex only.
// - Bit 7 collision test ignores writes, always reads zero.
// - Speed bits 6 and 13 ignore writes, always read 00.
// - Bit 5 unidirectional enable ignores writes, always reads zero.
// - Aliased functions use one storage element seen from every address.
module c22r_regs #(
  parameter logic [15:0] ID_HIGH = 16'h1234, // Arbitrary value
  parameter logic [15:0] ID_LOW  = 16'h5678  // Arbitrary value
) (
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic       clk_en_i,
  input  wire logic       mdc_i,
  input  wire logic       mdio_in_i,
  output logic            mdio_out_o,
  output logic            mdio_oe_n_o,
  input  wire logic [4:0] phy_addr_i,
  input  wire logic       powerdown_strap_pin_i,
  input  wire logic       link_up_i,
  input  wire logic       an_complete_i,
  input  wire logic       vendor_soft_reset_bit_i,
  input  wire logic       vendor_loop_we_i,
  input  wire logic       vendor_loop_d_i,
  input  wire logic       vendor_powerdown_we_i,
  input  wire logic       vendor_powerdown_d_i,
  input  wire logic       autoneg_mirror_we_i,
  input  wire logic       autoneg_mirror_d_i,
  output logic            soft_reset_o,
  output logic            pcs_loop_enable_o,
  output logic            powerdown_o,
  output logic            mac_isolate_o,
  output logic            autoneg_enable_o
);

  // **********************************************************
  // Read decode
  // **********************************************************
  function automatic c22r_pkg::c22r_word_t rd_word(
    input logic [4:0] a,
    input logic       rst_b,
    input logic       loop_b,
    input logic       an_b,
    input logic       pd_b,
    input logic       iso_b,
    input logic       lnk_b,
    input logic       and_b,
    input c22r_pkg::c22r_word_t mc,
    input c22r_pkg::c22r_word_t md
  );
    c22r_pkg::c22r_word_t w;
    w = 16'h0000;
    unique case (a)
      `C22R_OFS_CTRL: begin
        w[`C22R_B_SFT_RST] = rst_b;
        w[`C22R_B_LOOP]    = loop_b;
        w[`C22R_B_AUTONEG_ENABLE_MIRROR]   = an_b;
        w[`C22R_B_PD]      = pd_b;
        w[`C22R_B_ISO]     = iso_b;
        w[`C22R_B_DUPLEX]  = 1'b1;
      end
      `C22R_OFS_STAT: begin
        w = `C22R_RST_STAT;
        w[`C22R_B_LINK]    = lnk_b;
        w[`C22R_B_AN_DONE] = and_b;
      end
      `C22R_OFS_IDH: w = ID_HIGH;
      `C22R_OFS_IDL: w = ID_LOW;
      `C22R_OFS_MMDC: w = mc;
      `C22R_OFS_MMDD: w = md;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction : rd_word

  localparam c22r_pkg::c22r_word_t CTRL_RST = `C22R_RST_CTRL;

  // **********************************************************
  // State
  // **********************************************************
  c22r_pkg::c22r_state_e state_reg;
  logic [5:0]            cnt_reg;
  logic [15:0]           shf_reg;
  logic                  mdc_d_reg;
  logic                  rst_bit_reg;
  logic [7:0]            rst_cnt_reg;
  logic                  link_lat_reg;
  c22r_pkg::c22r_word_t  mmdc_reg;
  c22r_pkg::c22r_word_t  mmdd_reg;

  // **********************************************************
  // Frame decode
  // **********************************************************
  wire       rise      = mdc_i & ~mdc_d_reg;
  wire       step      = clk_en_i & rise;
  wire [15:0] shf_in   = {shf_reg[14:0], mdio_in_i};
  wire       hdr_done  = (state_reg == c22r_pkg::C22R_HDR) &&
                         (cnt_reg[3:0] == `C22R_HDR_BITS - 4'h1);
  // shf_in[12:0] = ST low bit, OP, PHY address, register address
  wire       hdr_st    = shf_in[12];
  wire [1:0] hdr_op    = shf_in[11:10];
  wire [4:0] hdr_phy   = shf_in[9:5];
  wire [4:0] hdr_reg   = shf_in[4:0];
  wire       hdr_me    = hdr_st && (hdr_phy == phy_addr_i);
  wire       go_rd     = step && hdr_done && hdr_me &&
                         (hdr_op == `C22R_OP_RD);
  wire       go_wr     = step && hdr_done && hdr_me &&
                         (hdr_op == `C22R_OP_WR);
  wire       wr_done   = step && (state_reg == c22r_pkg::C22R_WDAT) &&
                         (cnt_reg == 6'h0F);
  logic [4:0] addr_reg;
  wire       wr_ctrl   = wr_done && (addr_reg == `C22R_OFS_CTRL);
  wire       rd_stat   = go_rd && (hdr_reg == `C22R_OFS_STAT);
  wire [15:0] rd_val   = rd_word(hdr_reg, rst_bit_reg, pcs_loop_enable_o,
                                 autoneg_enable_o, powerdown_o,
                                 mac_isolate_o, link_lat_reg,
                                 an_complete_i, mmdc_reg, mmdd_reg);

  // **********************************************************
  // Management frame engine
  // **********************************************************
  // Sampling and driving both on the rising management clock edge
  // gives the host a full management clock period of setup.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg   <= c22r_pkg::C22R_PRE;
      cnt_reg     <= 6'h00;
      shf_reg     <= 16'h0000;
      addr_reg    <= 5'h00;
      // Track pin level so an idle-high MDC gives no false rise
      mdc_d_reg   <= mdc_i;
      mdio_out_o  <= 1'b1;
      mdio_oe_n_o <= 1'b1;
    end else if (clk_en_i) begin
      mdc_d_reg <= mdc_i;
      if (rise) begin
        shf_reg <= shf_in;
        unique case (state_reg)
          c22r_pkg::C22R_PRE: begin
            // Preamble suppression unsupported: 32 ones required
            if (mdio_in_i) begin
              if (cnt_reg != `C22R_PRE_ONES) cnt_reg <= cnt_reg + 6'h01;
            end else if (cnt_reg == `C22R_PRE_ONES) begin
              state_reg <= c22r_pkg::C22R_HDR;
              cnt_reg   <= 6'h00;
            end else begin
              cnt_reg <= 6'h00;
            end
          end
          c22r_pkg::C22R_HDR: begin
            cnt_reg  <= cnt_reg + 6'h01;
            addr_reg <= hdr_reg;
            if (hdr_done) begin
              cnt_reg   <= 6'h00;
              state_reg <= go_rd ? c22r_pkg::C22R_RTA :
                           go_wr ? c22r_pkg::C22R_WTA :
                                   c22r_pkg::C22R_PRE;
              if (go_rd) shf_reg <= rd_val;
            end
          end
          c22r_pkg::C22R_RTA: begin
            shf_reg     <= shf_reg;
            mdio_out_o  <= 1'b0;
            mdio_oe_n_o <= 1'b0;
            state_reg   <= c22r_pkg::C22R_RDAT;
          end
          c22r_pkg::C22R_RDAT: begin
            shf_reg <= {shf_reg[14:0], 1'b0};
            cnt_reg <= cnt_reg + 6'h01;
            mdio_out_o <= shf_reg[15];
            if (cnt_reg == 6'h10) begin
              mdio_out_o  <= 1'b1;
              mdio_oe_n_o <= 1'b1;
              cnt_reg     <= 6'h00;
              state_reg   <= c22r_pkg::C22R_PRE;
            end
          end
          c22r_pkg::C22R_WTA: begin
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == 6'h01) begin
              cnt_reg   <= 6'h00;
              state_reg <= c22r_pkg::C22R_WDAT;
            end
          end
          c22r_pkg::C22R_WDAT: begin
            cnt_reg <= cnt_reg + 6'h01;
            if (wr_done) begin
              cnt_reg   <= 6'h00;
              state_reg <= c22r_pkg::C22R_PRE;
            end
          end
          default: state_reg <= c22r_pkg::C22R_PRE;
        endcase
      end
    end
  end

  // **********************************************************
  // Control word storage, one element per aliased function
  // **********************************************************
  wire rst_start = (wr_ctrl && shf_in[`C22R_B_SFT_RST]) ||
                   vendor_soft_reset_bit_i;
  wire rst_end   = rst_bit_reg &&
                   (rst_cnt_reg == 8'(`C22R_SRST_CYC - 1));

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rst_bit_reg       <= 1'b0;
      rst_cnt_reg       <= 8'h00;
      soft_reset_o      <= 1'b0;
      pcs_loop_enable_o <= CTRL_RST[`C22R_B_LOOP];
      autoneg_enable_o  <= CTRL_RST[`C22R_B_AUTONEG_ENABLE_MIRROR];
      powerdown_o       <= powerdown_strap_pin_i;
      mac_isolate_o     <= CTRL_RST[`C22R_B_ISO];
    end else if (clk_en_i) begin
      if (rst_start && !rst_bit_reg) begin
        rst_bit_reg  <= 1'b1;
        rst_cnt_reg  <= 8'h00;
        soft_reset_o <= 1'b1;
      end else if (rst_end) begin // self-clearing
        rst_bit_reg       <= 1'b0;
        soft_reset_o      <= 1'b0;
        pcs_loop_enable_o <= 1'b0;
        mac_isolate_o     <= 1'b0;
      end else if (rst_bit_reg) begin
        rst_cnt_reg <= rst_cnt_reg + 8'h01;
      end
      if (!rst_bit_reg) begin
        // Vendor alias first; a management write in the same cycle wins
        if (vendor_loop_we_i) pcs_loop_enable_o <= vendor_loop_d_i;
        if (vendor_powerdown_we_i) powerdown_o <= vendor_powerdown_d_i;
        if (autoneg_mirror_we_i) autoneg_enable_o <= autoneg_mirror_d_i;
        if (wr_ctrl) begin
          pcs_loop_enable_o <= shf_in[`C22R_B_LOOP];
          powerdown_o       <= shf_in[`C22R_B_PD];
          mac_isolate_o     <= shf_in[`C22R_B_ISO];
        end
      end
    end
  end

  // **********************************************************
  // Status latch and indirect access words
  // **********************************************************
  // Frame engine is never gated by power-down, so access stays live
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      link_lat_reg <= 1'b0;
      mmdc_reg     <= `C22R_RST_MMDC;
      mmdd_reg     <= `C22R_RST_MMDD;
    end else if (clk_en_i) begin
      // Link drop wins over the set-on-read
      if (!link_up_i) link_lat_reg <= 1'b0;
      else if (rd_stat) link_lat_reg <= 1'b1;
      if (wr_done && addr_reg == `C22R_OFS_MMDC) mmdc_reg <= shf_in;
      if (wr_done && addr_reg == `C22R_OFS_MMDD) mmdd_reg <= shf_in;
    end
  end

endmodule : c22r_regs

// ---- tb/c22r_regs_chk.sv ----
`timescale 1ns/1ps
module c22r_regs_chk (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic mdio_out_o,
  input wire logic mdio_oe_n_o,
  input wire logic powerdown_strap_pin_i,
  input wire logic vendor_soft_reset_bit_i,
  input wire logic vendor_loop_we_i,
  input wire logic vendor_loop_d_i,
  input wire logic vendor_powerdown_we_i,
  input wire logic vendor_powerdown_d_i,
  input wire logic autoneg_mirror_we_i,
  input wire logic autoneg_mirror_d_i,
  input wire logic soft_reset_o,
  input wire logic pcs_loop_enable_o,
  input wire logic powerdown_o,
  input wire logic mac_isolate_o,
  input wire logic autoneg_enable_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  a_rst_vals: assert property (disable iff (1'b0) srst_i |=>
    mdio_oe_n_o && mdio_out_o && !soft_reset_o && autoneg_enable_o &&
    !pcs_loop_enable_o && !mac_isolate_o) else $error("reset values");
  a_strap_cap: assert property (disable iff (1'b0) srst_i |=>
    powerdown_o == $past(powerdown_strap_pin_i)) else $error("strap");
  a_srst_len: assert property ($rose(soft_reset_o) |->
    ##39 soft_reset_o ##1 !soft_reset_o) else $error("soft reset length");
  a_srst_end: assert property ($fell(soft_reset_o) |->
    ##[0:1] (!pcs_loop_enable_o && !mac_isolate_o)) else $error("srst end");
  a_vsrst_start: assert property (vendor_soft_reset_bit_i |=>
    soft_reset_o) else $error("vendor soft reset");
  a_loop_alias: assert property (vendor_loop_we_i |=>
    pcs_loop_enable_o == $past(vendor_loop_d_i)) else $error("loop alias");
  a_pd_alias: assert property (vendor_powerdown_we_i |=>
    powerdown_o == $past(vendor_powerdown_d_i)) else $error("pd alias");
  a_an_alias: assert property (autoneg_mirror_we_i |=>
    autoneg_enable_o == $past(autoneg_mirror_d_i)) else $error("an alias");
  c_srst: cover property ($rose(soft_reset_o));
  c_drive: cover property ($fell(mdio_oe_n_o));
  c_loop: cover property (vendor_loop_we_i && vendor_loop_d_i);
endmodule : c22r_regs_chk

// ---- tb/c22r_host.sv ----
`timescale 1ns/1ps
module c22r_host (
  input  wire logic sys_clk_i,
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_en_o
);
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_en_o = 1'b0;
  end
  // Four clocks per MDC phase, double the minimum
  task step(input logic en, input logic b, output logic s);
    mdio_en_o = en;
    mdio_o = b;
    mdc_o = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    s = mdio_i;
    mdc_o = 1'b1;
    repeat (4) @(negedge sys_clk_i);
  endtask : step
  task xfer(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
            input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, wr ? 2'b01 : 2'b10, pa, ra};
    for (int i = 0; i < 32; i++) step(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) step(1'b1, hdr[i], s);
    step(wr, 1'b1, s);
    step(wr, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      step(wr, wd[i], s);
      rd[i] = s;
    end
    mdio_en_o = 1'b0;
    mdio_o = 1'b1;
    @(negedge sys_clk_i);
  endtask : xfer
endmodule : c22r_host

// ---- tb/c22r_regs_test.sv ----
`timescale 1ns/1ps
module c22r_regs_test;
  localparam logic [15:0] ID_H = 16'hA5C3; // Arbitrary value
  localparam logic [15:0] ID_L = 16'h3C5A; // Arbitrary value
  localparam logic [4:0]  PA   = 5'h05;
  typedef struct packed {
    logic [4:0] ofs; logic [15:0] wd; logic [15:0] exp;
  } c22r_row_s;
  c22r_row_s   rows [8] = '{'{5'h01, 16'hFFFF, 16'h1009},
    '{5'h02, 16'h0000, ID_H}, '{5'h03, 16'h0000, ID_L},
    '{5'h0D, 16'hBEEF, 16'hBEEF}, '{5'h0E, 16'h1357, 16'h1357},
    '{5'h1F, 16'hFFFF, 16'h0000}, '{5'h00, 16'h0000, 16'h1100},
    '{5'h00, 16'h7EFF, 16'h5D00}};
  logic        clk, srst, strap, vsr, vlwe, vld, vpwe, vpd, anwe, and_d;
  logic        mdc, h_out, h_en, d_out, d_oe_n, sr_o, loop, pd, iso, an;
  logic [15:0] rd;
  int          err_count = 0;
  int          checks_done = 0;
  wire         mdio = !d_oe_n ? d_out : (h_en ? h_out : 1'b1);
  c22r_regs #(.ID_HIGH(ID_H), .ID_LOW(ID_L)) i_dut (.sys_clk_i(clk),
    .srst_i(srst), .clk_en_i(1'b1), .mdc_i(mdc), .mdio_in_i(mdio),
    .mdio_out_o(d_out), .mdio_oe_n_o(d_oe_n), .phy_addr_i(PA),
    .powerdown_strap_pin_i(strap), .link_up_i(1'b0), .an_complete_i(1'b0),
    .vendor_soft_reset_bit_i(vsr), .vendor_loop_we_i(vlwe),
    .vendor_loop_d_i(vld), .vendor_powerdown_we_i(vpwe),
    .vendor_powerdown_d_i(vpd), .autoneg_mirror_we_i(anwe),
    .autoneg_mirror_d_i(and_d), .soft_reset_o(sr_o),
    .pcs_loop_enable_o(loop), .powerdown_o(pd), .mac_isolate_o(iso),
    .autoneg_enable_o(an));
  c22r_host i_host (.sys_clk_i(clk), .mdio_i(mdio), .mdc_o(mdc),
    .mdio_o(h_out), .mdio_en_o(h_en));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task results;
    $display("Mismatches %0d, checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task rst(input logic s);
    strap = s;
    srst = 1'b1;
    repeat (4) @(negedge clk);
    srst = 1'b0;
  endtask : rst
  task mrd(input logic [4:0] ra);
    i_host.xfer(1'b0, PA, ra, 16'h0000, rd);
  endtask : mrd
  task mwr(input logic [4:0] ra, input logic [15:0] wd);
    i_host.xfer(1'b1, PA, ra, wd, rd);
  endtask : mwr
  initial begin
    {srst, strap, vsr, vlwe, vld, vpwe, vpd, anwe, and_d} = 9'h100;
    rst(1'b0);
    mrd(5'h00);
    chk(rd, 16'h1100);
    chk({12'h000, loop, pd, iso, an}, 16'h0001);
    foreach (rows[k]) begin
      mwr(rows[k].ofs, rows[k].wd);
      mrd(rows[k].ofs);
      chk(rd, rows[k].exp);
    end
    chk({12'h000, loop, pd, iso, an}, 16'h000F);
    mrd(5'h00);
    mwr(5'h00, rd | 16'h8000);
    chk({15'h0000, sr_o}, 16'h0001);
    repeat (40) @(negedge clk);
    chk({12'h000, loop, pd, iso, an}, 16'h0005);
    mrd(5'h00);
    chk(rd, 16'h1900);
    {vlwe, vld, vpwe, vpd, anwe, and_d} = 6'h3A;
    @(negedge clk);
    {vlwe, vpwe, anwe} = 3'h0;
    mrd(5'h00);
    chk(rd, 16'h4100);
    vsr = 1'b1;
    @(negedge clk);
    vsr = 1'b0;
    @(negedge clk);
    chk({15'h0000, sr_o}, 16'h0001);
    repeat (45) @(negedge clk);
    rst(1'b1);
    i_host.xfer(1'b1, PA ^ 5'h01, 5'h00, 16'h0000, rd);
    mrd(5'h00);
    chk(rd, 16'h1900);
    results;
  end
endmodule : c22r_regs_test
bind c22r_regs c22r_regs_chk i_chk (.*);
